// ===== logic/btp_pkg.sv
// btp_pkg: constants and carrier types for the bridge traffic policy block
package btp_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_THRESH  = 8'h04;
  localparam logic [7:0] OFS_TRAPMIN = 8'h08;
  localparam logic [7:0] OFS_AGE     = 8'h0C;
  localparam logic [7:0] OFS_MAC_LO  = 8'h10;
  localparam logic [7:0] OFS_MAC_HI  = 8'h14;
  localparam logic [7:0] OFS_CMD     = 8'h18;
  localparam logic [7:0] OFS_SEL     = 8'h1C;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_DROPS   = 8'h24;
  localparam logic [7:0] OFS_ENT_LO  = 8'h28;
  localparam logic [7:0] OFS_ENT_HI  = 8'h2C;
  // control field positions
  localparam int CTL_LIM   = 0;  // 2 bits
  localparam int CTL_RELAY = 2;  // 2 bits
  localparam int CTL_UREL  = 4;
  localparam int CTL_ALLOW = 5;
  localparam int CTL_ADMIT = 6;
  localparam int CTL_ROAM  = 7;
  localparam int CTL_ETH   = 8;
  localparam int CTL_AU    = 9;
  localparam int CMD_ADD   = 0;
  localparam int CMD_REM   = 1;
  // reset values and ranges
  localparam logic [9:0]  CTRL_RST    = 10'h154;
  localparam logic [17:0] THRESH_RST  = 18'h00032;
  localparam logic [17:0] THRESH_MAX  = 18'h32000;
  localparam logic [5:0]  TRAPMIN_RST = 6'h05;
  localparam logic [5:0]  TRAPMIN_MAX = 6'h3C;
  localparam logic [10:0] AGE_RST     = 11'h12C;
  localparam logic [10:0] AGE_MIN     = 11'h014;
  localparam logic [10:0] AGE_MAX     = 11'h7D0;
  localparam logic [11:0] SEC_PER_MIN = 12'h03C;
  // timing
  localparam longint SEC_NS       = 1000000000;
  localparam longint CLK_NS       = 4;
  localparam int     SEC_CYC_DEF  = int'(SEC_NS / CLK_NS);
  localparam int     LOSS_SLOW_S  = 7;
  localparam int     LOSS_FAST_S  = 1;
  // limiter and relay modes
  typedef enum logic [1:0] {
    LIM_OFF = 2'h0, LIM_BC = 2'h1, LIM_MC = 2'h2, LIM_ALL = 2'h3
  } btp_lim_t;
  typedef enum logic [1:0] {
    REL_OFF = 2'h0, REL_BOTH = 2'h1, REL_BC = 2'h2, REL_MC = 2'h3
  } btp_rel_t;
  // packet descriptor in, forwarding decision out
  typedef struct packed {
    logic from_wl;
    logic bcast;
    logic mcast;
    logic mgmt;
    logic dst_wl;
    logic roam;
    logic filt_ok;
  } btp_pkt_t;
  typedef struct packed {
    logic to_wired;
    logic to_wl;
    logic drop;
    logic learn;
  } btp_dec_t;
endpackage : btp_pkg

// ===== logic/btp_top.sv
// btp_top: bridge traffic policy, limiter, relay, station list, roaming
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module btp_top #(
  parameter int          SEC_CYC  = btp_pkg::SEC_CYC_DEF,
  parameter int          LIST_MAX = 100,
  parameter logic [23:0] PREFIX   = 24'h5A5A5A  // arbitrary value
) (
  input  wire logic             SYS_CLK,
  input  wire logic             SYS_RST,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [31:0]      REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic [31:0]           REG_RDATA,
  input  wire logic             PKT_VALID,
  input  wire btp_pkg::btp_pkt_t PKT,
  output logic                  DEC_VALID,
  output btp_pkg::btp_dec_t     DEC,
  output logic                  TRAP_VALID,
  output logic [31:0]           TRAP_COUNT,
  output logic                  SEC_TICK,
  input  wire logic             AGE_CHK_VALID,
  input  wire logic [11:0]      AGE_CHK_IDLE,
  input  wire logic             AGE_CHK_SYS,
  output logic                  AGE_REMOVE,
  input  wire logic             ASSOC_VALID,
  input  wire logic [47:0]      ASSOC_MAC,
  output logic                  ASSOC_DONE,
  output logic                  ASSOC_ADMIT,
  output logic                  ASSOC_TRAFFIC,
  input  wire logic             BEACON_SEEN,
  output logic                  SCAN_START,
  input  wire logic             NEW_ASSOC,
  input  wire logic [7:0]       CLIENT_CNT,
  output logic [7:0]            CLIENT_IDX,
  input  wire logic [47:0]      CLIENT_MAC,
  output logic                  ANN_VALID,
  output logic [47:0]           ANN_SRC,
  output logic                  PORT_KILL
);
  if (SEC_CYC < 2 || LIST_MAX < 1 || LIST_MAX > 127) begin : g_chk
    $error("btp_top: unsupported parameter value");
  end

  typedef enum logic [1:0] {ANN_IDLE = 2'b01, ANN_SEND = 2'b10} btp_ann_t;
  localparam logic [31:0] SEC_C = 32'(SEC_CYC);
  localparam logic [31:0] LOSS_SLOW = 32'(SEC_CYC * btp_pkg::LOSS_SLOW_S);
  localparam logic [31:0] LOSS_FAST = 32'(SEC_CYC * btp_pkg::LOSS_FAST_S);

  logic [9:0]  ctrl_q;
  logic [17:0] thresh_q;
  logic [5:0]  trapmin_q;
  logic [10:0] age_q;
  logic [47:0] mac_q;
  logic [6:0]  sel_q;
  logic [47:0] list_q [LIST_MAX];
  logic [6:0]  cnt_q;
  logic [31:0] sec_q;
  logic        tick;
  logic [17:0] win_q;
  logic        over_q;
  logic [31:0] drop_q;
  logic [11:0] wait_q;
  logic [31:0] loss_q;
  logic        lost_q;
  logic        first_q;
  btp_ann_t    ann_q;
  logic [7:0]  idx_q;
  logic [7:0]  total_q;
  logic        ann_go_q;
  logic        lim_hit;
  logic [7:0]  cmd_find;
  logic [7:0]  asc_find;
  btp_pkg::btp_dec_t dec_d;

  // linear search of the station list: {found, index}
  function automatic logic [7:0] find(input logic [47:0] mac,
                                      input logic [6:0] n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < LIST_MAX; i++) begin
      if (7'(i) < n && list_q[i] == mac && !r[7]) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction : find

  assign cmd_find = find(mac_q, cnt_q);
  assign asc_find = find(ASSOC_MAC, cnt_q);

  ////////////////////////////////////////////////////////////////////////
  // register writes, out-of-range values dropped
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl_q    <= btp_pkg::CTRL_RST;
      thresh_q  <= btp_pkg::THRESH_RST;
      trapmin_q <= btp_pkg::TRAPMIN_RST;
      age_q     <= btp_pkg::AGE_RST;
      mac_q     <= 48'h0;
      sel_q     <= 7'h00;
    end else if (REG_WR) begin
      case (REG_ADDR)
        btp_pkg::OFS_CTRL:   ctrl_q <= REG_WDATA[9:0];
        btp_pkg::OFS_THRESH:
          if (REG_WDATA <= 32'(btp_pkg::THRESH_MAX)) begin
            thresh_q <= REG_WDATA[17:0];
          end
        btp_pkg::OFS_TRAPMIN:
          if (REG_WDATA != 32'h0 &&
              REG_WDATA <= 32'(btp_pkg::TRAPMIN_MAX)) begin
            trapmin_q <= REG_WDATA[5:0];
          end
        btp_pkg::OFS_AGE:
          if (REG_WDATA >= 32'(btp_pkg::AGE_MIN) &&
              REG_WDATA <= 32'(btp_pkg::AGE_MAX)) begin
            age_q <= REG_WDATA[10:0];
          end
        btp_pkg::OFS_MAC_LO: mac_q[31:0]  <= REG_WDATA;
        btp_pkg::OFS_MAC_HI: mac_q[47:32] <= REG_WDATA[15:0];
        btp_pkg::OFS_SEL:    sel_q <= REG_WDATA[6:0];
        default: ;
      endcase
    end
  end

  // station list add and remove; removal moves the last entry in
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cnt_q <= 7'h00;
    end else if (REG_WR && REG_ADDR == btp_pkg::OFS_CMD) begin
      if (REG_WDATA[btp_pkg::CMD_ADD] && !cmd_find[7] &&
          cnt_q < 7'(LIST_MAX)) begin
        list_q[cnt_q] <= mac_q;
        cnt_q <= cnt_q + 7'h01;
      end else if (REG_WDATA[btp_pkg::CMD_REM] && cmd_find[7]) begin
        list_q[cmd_find[6:0]] <= list_q[cnt_q - 7'h01];
        cnt_q <= cnt_q - 7'h01;
      end
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        btp_pkg::OFS_CTRL:    REG_RDATA <= {22'h0, ctrl_q};
        btp_pkg::OFS_THRESH:  REG_RDATA <= {14'h0, thresh_q};
        btp_pkg::OFS_TRAPMIN: REG_RDATA <= {26'h0, trapmin_q};
        btp_pkg::OFS_AGE:     REG_RDATA <= {21'h0, age_q};
        btp_pkg::OFS_MAC_LO:  REG_RDATA <= mac_q[31:0];
        btp_pkg::OFS_MAC_HI:  REG_RDATA <= {16'h0, mac_q[47:32]};
        btp_pkg::OFS_SEL:     REG_RDATA <= {25'h0, sel_q};
        btp_pkg::OFS_STATUS:
          REG_RDATA <= {21'h0, lost_q, ctrl_q[btp_pkg::CTL_ALLOW],
                        over_q, 1'b0, cnt_q};
        btp_pkg::OFS_DROPS:   REG_RDATA <= drop_q;
        btp_pkg::OFS_ENT_LO:
          REG_RDATA <= (sel_q < cnt_q) ? list_q[sel_q][31:0] : 32'h0;
        btp_pkg::OFS_ENT_HI:
          REG_RDATA <= (sel_q < cnt_q) ?
                       {16'h0, list_q[sel_q][47:32]} : 32'h0;
        default:              REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one-second window timer
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sec_q <= 32'h0;
    end else begin
      sec_q <= tick ? 32'h0 : sec_q + 32'h1;
    end
  end
  assign tick = (sec_q == SEC_C - 32'h1);
  assign SEC_TICK = tick;

  // limiter packet selection after the broadcast filters
  always_comb begin
    logic sel;
    sel = 1'b0;
    case (btp_pkg::btp_lim_t'(ctrl_q[btp_pkg::CTL_LIM +: 2]))
      btp_pkg::LIM_BC:  sel = PKT.bcast;
      btp_pkg::LIM_MC:  sel = PKT.mcast && !PKT.bcast;
      btp_pkg::LIM_ALL: sel = PKT.mcast || PKT.bcast;
      default:          sel = 1'b0;
    endcase
    lim_hit = PKT_VALID && PKT.filt_ok && sel;
  end

  // window count and over-limit flag, cleared each window
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      win_q  <= 18'h0;
      over_q <= 1'b0;
    end else if (tick) begin
      win_q  <= 18'h0;
      over_q <= 1'b0;
    end else if (lim_hit) begin
      if (win_q < thresh_q) begin
        win_q <= win_q + 18'h1;
      end else begin
        over_q <= 1'b1;
      end
    end
  end

  // drop tally and trap pacing
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      drop_q     <= 32'h0;
      wait_q     <= 12'h0;
      TRAP_VALID <= 1'b0;
      TRAP_COUNT <= 32'h0;
    end else begin
      TRAP_VALID <= 1'b0;
      if (tick && wait_q != 12'h0) begin
        wait_q <= wait_q - 12'h1;
      end
      if (tick && over_q && wait_q == 12'h0) begin
        TRAP_VALID <= 1'b1;
        TRAP_COUNT <= drop_q;
        drop_q     <= 32'h0;
        wait_q     <= 12'(trapmin_q * btp_pkg::SEC_PER_MIN);
      end else if (lim_hit && !tick && win_q >= thresh_q) begin
        drop_q <= drop_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // forwarding decision per packet
  always_comb begin
    dec_d = '{to_wired: PKT.from_wl, to_wl: !PKT.from_wl,
              drop: 1'b0, learn: 1'b0};
    if (ctrl_q[btp_pkg::CTL_AU] && PKT.from_wl) begin
      if (PKT.roam) begin
        dec_d.to_wired = 1'b1;
        dec_d.to_wl    = 1'b1;
        dec_d.learn    = 1'b1;
      end else if (PKT.bcast || PKT.mcast) begin
        dec_d.to_wired = 1'b1;
        case (btp_pkg::btp_rel_t'(ctrl_q[btp_pkg::CTL_RELAY +: 2]))
          btp_pkg::REL_BOTH: dec_d.to_wl = 1'b1;
          btp_pkg::REL_BC:   dec_d.to_wl = PKT.bcast;
          btp_pkg::REL_MC:   dec_d.to_wl = !PKT.bcast;
          default:           dec_d.to_wl = 1'b0;
        endcase
      end else begin
        dec_d.to_wired = !PKT.dst_wl;
        dec_d.to_wl = PKT.dst_wl && ctrl_q[btp_pkg::CTL_UREL];
        dec_d.drop  = PKT.dst_wl && !ctrl_q[btp_pkg::CTL_UREL];
      end
    end
    if (!ctrl_q[btp_pkg::CTL_AU] && !ctrl_q[btp_pkg::CTL_ETH] &&
        !PKT.mgmt) begin
      dec_d = '{to_wired: 1'b0, to_wl: 1'b0, drop: 1'b1,
                learn: 1'b0};
    end
    if (lim_hit && win_q >= thresh_q) begin
      dec_d = '{to_wired: 1'b0, to_wl: 1'b0, drop: 1'b1,
                learn: 1'b0};
    end
  end

  // registered decision and session kill on port disable
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      DEC_VALID <= 1'b0;
      DEC       <= '0;
      PORT_KILL <= 1'b0;
    end else begin
      DEC_VALID <= PKT_VALID;
      DEC       <= PKT_VALID ? dec_d : '0;
      PORT_KILL <= REG_WR && REG_ADDR == btp_pkg::OFS_CTRL &&
                   ctrl_q[btp_pkg::CTL_ETH] &&
                   !REG_WDATA[btp_pkg::CTL_ETH];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // aging check, same-system units never removed
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      AGE_REMOVE <= 1'b0;
    end else begin
      AGE_REMOVE <= AGE_CHK_VALID && !AGE_CHK_SYS &&
                    AGE_CHK_IDLE >= {1'b0, age_q};
    end
  end

  // association admission and traffic permission
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ASSOC_DONE    <= 1'b0;
      ASSOC_ADMIT   <= 1'b0;
      ASSOC_TRAFFIC <= 1'b0;
    end else begin
      ASSOC_DONE  <= ASSOC_VALID;
      ASSOC_ADMIT <= ASSOC_VALID && (ctrl_q[btp_pkg::CTL_ADMIT] ||
                     ASSOC_MAC[47:24] == PREFIX);
      ASSOC_TRAFFIC <= ASSOC_VALID &&
        (ctrl_q[btp_pkg::CTL_ALLOW] ? asc_find[7]
                                    : !asc_find[7]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // beacon loss timer, scan pulse once per outage
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      loss_q     <= 32'h0;
      lost_q     <= 1'b0;
      SCAN_START <= 1'b0;
    end else begin
      SCAN_START <= 1'b0;
      if (BEACON_SEEN) begin
        loss_q <= 32'h0;
        lost_q <= 1'b0;
      end else if (!lost_q) begin
        loss_q <= loss_q + 32'h1;
        if (loss_q + 32'h1 >= (ctrl_q[btp_pkg::CTL_ROAM] ?
                               LOSS_FAST : LOSS_SLOW)) begin
          lost_q     <= 1'b1;
          SCAN_START <= 1'b1;
        end
      end
    end
  end

  // announcement sequencer, one per client per new association after the first since reset
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ann_q    <= ANN_IDLE;
      first_q  <= 1'b1;
      idx_q    <= 8'h0;
      total_q  <= 8'h0;
      ann_go_q <= 1'b0;
      ANN_SRC  <= 48'h0;
    end else begin
      ann_go_q <= 1'b0;
      case (ann_q)
        ANN_IDLE:
          if (NEW_ASSOC) begin
            first_q <= 1'b0;
            if (!first_q && ctrl_q[btp_pkg::CTL_ROAM] &&
                CLIENT_CNT != 8'h0) begin
              ann_q   <= ANN_SEND;
              idx_q   <= 8'h0;
              total_q <= CLIENT_CNT;
            end
          end
        ANN_SEND: begin
          ann_go_q <= 1'b1;
          ANN_SRC  <= CLIENT_MAC;
          idx_q    <= idx_q + 8'h1;
          if (idx_q + 8'h1 == total_q) begin
            ann_q <= ANN_IDLE;
          end
        end
        default: ann_q <= ANN_IDLE;
      endcase
    end
  end
  assign ANN_VALID  = ann_go_q;
  assign CLIENT_IDX = idx_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_rm_wr;
    REG_WR && REG_ADDR == btp_pkg::OFS_THRESH;
  endsequence
  sequence s_first_assoc;
    NEW_ASSOC && first_q;
  endsequence

  lim_off_a: assert property (ctrl_q[1:0] == 2'h0 |-> !lim_hit)
    else $error("limiter selected a packet while off");
  thr_range_a: assert property (s_rm_wr ##1 1'b1
      |-> thresh_q <= btp_pkg::THRESH_MAX)
    else $error("threshold out of range");
  win_cap_a: assert property (win_q <= thresh_q || $past(tick))
    else $error("window count passed threshold");
  win_clr_a: assert property (tick |=> win_q == 18'h0)
    else $error("window count not cleared");
  trap_space_a: assert property (TRAP_VALID |=> !TRAP_VALID [*8])
    else $error("traps too close");
  trap_cause_a: assert property (TRAP_VALID |-> $past(over_q))
    else $error("trap without limit reached");
  age_sys_a: assert property (AGE_CHK_VALID && AGE_CHK_SYS
      |=> !AGE_REMOVE)
    else $error("system unit aged out");
  list_max_a: assert property (cnt_q <= 7'(LIST_MAX))
    else $error("station list overfull");
  relay_off_a: assert property (DEC_VALID && DEC.to_wl &&
      $past(PKT.from_wl && ctrl_q[btp_pkg::CTL_AU] && !PKT.roam &&
      (PKT.bcast || PKT.mcast)) |-> $past(ctrl_q[3:2]) != 2'h0)
    else $error("relayed with relay off");
  first_skip_a: assert property (s_first_assoc |=> ann_q == ANN_IDLE)
    else $error("announced on first association");
  scan_bound_a: assert property (SCAN_START |-> $past(loss_q) + 32'h1 >=
      LOSS_FAST)
    else $error("scan started early");
  eth_block_a: assert property (PKT_VALID && !ctrl_q[btp_pkg::CTL_AU] &&
      !ctrl_q[btp_pkg::CTL_ETH] && !PKT.mgmt |=> DEC.drop)
    else $error("data passed disabled port");
endmodule : btp_top

// ===== tb/btp_lan_model.sv
// btp_lan_model: bridging table of the clients behind the unit
`timescale 1ns/1ps
module btp_lan_model (
  input  wire logic [7:0]  client_idx,
  output logic      [47:0] client_mac
);
  // one distinct client address per table slot
  assign client_mac = {40'h0A0B0C0D00, client_idx};
endmodule : btp_lan_model

// ===== tb/tb_btp_top.sv
// tb_btp_top: scenario bench for the bridge traffic policy block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WAITN(n, c) begin for (wi = 0; wi < (n) && !(c); wi++) \
  @(negedge clk); if (!(c)) begin fails++; end_of_test(); end end
module tb_btp_top;
  localparam int SC = 20;
  logic              clk, rst, wr, rd, pv, acv, acs, bcn, nas, dv, tv;
  logic              tick, arem, asv, adone, aadm, atrf, scan, annv, kill;
  logic [7:0]        addr, cnt, idx;
  logic [31:0]       wd, rdat, tcnt;
  logic [11:0]       idle;
  logic [47:0]       amac, cmac, asrc;
  btp_pkg::btp_pkt_t pkt;
  btp_pkg::btp_dec_t dec;
  int                fails, checks_done, wi, ann_n;
  logic [47:0]       ann_s [2];
  btp_top #(.SEC_CYC(SC)) i_dut (.SYS_CLK(clk), .SYS_RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdat), .PKT_VALID(pv), .PKT(pkt), .DEC_VALID(dv), .DEC(dec),
    .TRAP_VALID(tv), .TRAP_COUNT(tcnt), .SEC_TICK(tick),
    .AGE_CHK_VALID(acv), .AGE_CHK_IDLE(idle), .AGE_CHK_SYS(acs),
    .AGE_REMOVE(arem), .ASSOC_VALID(asv), .ASSOC_MAC(amac),
    .ASSOC_DONE(adone), .ASSOC_ADMIT(aadm), .ASSOC_TRAFFIC(atrf),
    .BEACON_SEEN(bcn), .SCAN_START(scan), .NEW_ASSOC(nas),
    .CLIENT_CNT(cnt), .CLIENT_IDX(idx), .CLIENT_MAC(cmac),
    .ANN_VALID(annv), .ANN_SRC(asrc), .PORT_KILL(kill));
  btp_lan_model i_lan (.client_idx(idx), .client_mac(cmac));
  // clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // announcement monitor
  always @(posedge clk) if (annv === 1'b1) begin
    if (ann_n < 2) ann_s[ann_n] <= asrc;
    ann_n <= ann_n + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdat & m)
  endtask : rd_reg
  task automatic send(input logic [6:0] p, input logic [2:0] m, e);
    @(posedge clk);
    pv <= 1'b1;
    pkt <= btp_pkg::btp_pkt_t'(p);
    @(posedge clk);
    pv <= 1'b0;
    #1 `CHK("dec_valid", 1'b1, dv)
    `CHK("dec", e, {dec.to_wired, dec.to_wl, dec.drop} & m)
  endtask : send
  task automatic assoc(input logic [47:0] mac, input logic ea, et);
    @(posedge clk);
    asv <= 1'b1;
    amac <= mac;
    @(posedge clk);
    asv <= 1'b0;
    #1 `CHK("assoc", {1'b1, ea, et}, {adone, aadm, atrf})
  endtask : assoc
  task automatic age(input logic [11:0] t, input logic s, e);
    @(posedge clk);
    acv <= 1'b1;
    idle <= t;
    acs <= s;
    @(posedge clk);
    acv <= 1'b0;
    #1 `CHK("age_remove", e, arem)
  endtask : age
  task automatic pulse_bcn_nas(input logic b);
    @(posedge clk);
    if (b) bcn <= 1'b1;
    else nas <= 1'b1;
    @(posedge clk);
    bcn <= 1'b0;
    nas <= 1'b0;
  endtask : pulse_bcn_nas
  ////////////////////////////////////////////////////////////////////////////
  // defaults, ranges, unmapped place
  task automatic t_regs();
    logic [7:0]  a [6] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h0C};
    logic [31:0] d [6] = '{32'h32001, 32'h32000, 32'h0, 32'h3D, 32'h13,
                           32'h7D1};
    logic [31:0] e [6] = '{32'h32, 32'h32000, 32'h5, 32'h5, 32'h12C,
                           32'h12C};
    rd_reg(btp_pkg::OFS_CTRL, 32'h3FF, 32'h154);
    rd_reg(btp_pkg::OFS_CTRL, 32'h1C0, 32'h140);
    rd_reg(btp_pkg::OFS_THRESH, 32'h3FFFF, 32'h32);
    rd_reg(btp_pkg::OFS_TRAPMIN, 32'h3F, 32'h5);
    rd_reg(btp_pkg::OFS_AGE, 32'h7FF, 32'h12C);
    rd_reg(8'hF0, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr_reg(a[i], d[i]);
      rd_reg(a[i], 32'h3FFFF, e[i]);
    end
  endtask : t_regs
  // beacon loss timing, roam off then on
  task automatic t_scan();
    for (int r = 0; r < 2; r++) begin
      wr_reg(btp_pkg::OFS_CTRL, r ? 32'h1D4 : 32'h154);
      pulse_bcn_nas(1'b1);
      `WAITN(8 * SC, scan === 1'b1)
      `CHK("scan", 1'b1, wi inside {[(r?1:7)*SC-3:(r?1:7)*SC+1]})
    end
  endtask : t_scan
  // limiter: drop beyond threshold, mode select, trap tally
  task automatic t_limit();
    wr_reg(btp_pkg::OFS_CTRL, 32'h155);
    wr_reg(btp_pkg::OFS_THRESH, 32'h2);
    `WAITN(SC + 5, tick === 1'b1)
    send(7'h31, 3'h1, 3'h0);
    send(7'h31, 3'h1, 3'h0);
    send(7'h31, 3'h1, 3'h1);
    send(7'h11, 3'h1, 3'h0);
    @(negedge clk);
    `WAITN(SC + 5, tick === 1'b1)
    @(negedge clk);
    `CHK("trap", 1'b1, tv)
    `CHK("trap_count", 32'h1, tcnt)
  endtask : t_limit
  // relaying on the access unit
  task automatic t_relay();
    logic [31:0] c [6] = '{32'h350, 32'h354, 32'h358, 32'h35C, 32'h344,
                           32'h354};
    logic [6:0]  p [6] = '{7'h71, 7'h71, 7'h51, 7'h51, 7'h45, 7'h45};
    logic [2:0]  m [6] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h2, 3'h2};
    logic [2:0]  e [6] = '{3'h4, 3'h6, 3'h4, 3'h6, 3'h0, 3'h2};
    for (int i = 0; i < 6; i++) begin
      wr_reg(btp_pkg::OFS_CTRL, c[i]);
      send(p[i], m[i], e[i]);
    end
    wr_reg(btp_pkg::OFS_CTRL, 32'h350);
    send(7'h43, 3'h7, 3'h6);
    `CHK("learn", 1'b1, dec.learn)
  endtask : t_relay
  // station list, actions, admission prefix
  task automatic t_list();
    logic [47:0] inl = 48'h5A5A5A123456;
    logic [47:0] outl = 48'h112233445566;
    wr_reg(btp_pkg::OFS_CTRL, 32'h154);
    wr_reg(btp_pkg::OFS_MAC_LO, 32'h5A123456);
    wr_reg(btp_pkg::OFS_MAC_HI, 32'h5A5A);
    wr_reg(btp_pkg::OFS_CMD, 32'h1);
    wr_reg(btp_pkg::OFS_CMD, 32'h1);
    rd_reg(btp_pkg::OFS_STATUS, 32'h27F, 32'h1);
    wr_reg(btp_pkg::OFS_SEL, 32'h0);
    rd_reg(btp_pkg::OFS_ENT_LO, 32'hFFFFFFFF, 32'h5A123456);
    rd_reg(btp_pkg::OFS_ENT_HI, 32'hFFFF, 32'h5A5A);
    assoc(inl, 1'b1, 1'b0);
    assoc(outl, 1'b1, 1'b1);
    wr_reg(btp_pkg::OFS_CTRL, 32'h174);
    rd_reg(btp_pkg::OFS_STATUS, 32'h27F, 32'h201);
    assoc(inl, 1'b1, 1'b1);
    assoc(outl, 1'b1, 1'b0);
    wr_reg(btp_pkg::OFS_CTRL, 32'h134);
    assoc(outl, 1'b0, 1'b0);
    assoc(inl, 1'b1, 1'b1);
    wr_reg(btp_pkg::OFS_CMD, 32'h2);
    rd_reg(btp_pkg::OFS_STATUS, 32'h7F, 32'h0);
  endtask : t_list
  // roaming announcements, ethernet port gating
  task automatic t_ann_port();
    wr_reg(btp_pkg::OFS_CTRL, 32'h1D4);
    cnt <= 8'h02;
    pulse_bcn_nas(1'b0);
    repeat (6) @(negedge clk);
    `CHK("ann_first", 0, ann_n)
    pulse_bcn_nas(1'b0);
    repeat (6) @(negedge clk);
    `CHK("ann_count", 2, ann_n)
    `CHK("ann_src0", 48'h0A0B0C0D0000, ann_s[0])
    `CHK("ann_src1", 48'h0A0B0C0D0001, ann_s[1])
    wr_reg(btp_pkg::OFS_CTRL, 32'h154);
    send(7'h01, 3'h1, 3'h0);
    wr_reg(btp_pkg::OFS_CTRL, 32'h054);
    `WAITN(4, kill === 1'b1)
    send(7'h01, 3'h1, 3'h1);
    send(7'h09, 3'h1, 3'h0);
  endtask : t_ann_port
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  // main sequence
  initial begin
    {rst, wr, rd, pv, acv, acs, asv, bcn, nas} = 9'h100;
    {addr, cnt, wd, idle, amac, ann_n} = '0;
    pkt = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_scan();
    t_limit();
    t_relay();
    t_list();
    age(12'h12B, 1'b0, 1'b0);
    age(12'h12D, 1'b0, 1'b1);
    age(12'h12D, 1'b1, 1'b0);
    t_ann_port();
    end_of_test();
  end
endmodule : tb_btp_top
